// >>> rtl/acq_pkg.sv
// Constants shared by the analog input control block and its helpers.
// Assumes a single 200 MHz system clock.
package acq_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int CONV_TIME_NS = 10000;
    localparam int DATA_AVAILABLE_MAX_NS = 12000;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int DATA_AVAILABLE_CYCLES = DATA_AVAILABLE_MAX_NS / CLK_PERIOD_NS;
    localparam int CONV_CNT_W = 12;
    localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);
    localparam logic [CONV_CNT_W-1:0] CONV_FULL = CONV_CNT_W'(CONV_CYCLES);
    localparam logic [CONV_CNT_W-1:0] CONV_ONE = 12'h001;

    // ==========================================================
    // Sample FIFO
    localparam int SAMPLE_W = 16;
    localparam int ADC_W = 12;
    localparam int FIFO_DEPTH = 4096;
    localparam int FIFO_AW = 12;
    localparam int FIFO_CW = 13;
    localparam logic [FIFO_CW-1:0] FIFO_FULL = 13'h1000;
    localparam logic [FIFO_CW-1:0] FIFO_HALF = 13'h0800;
    localparam logic [FIFO_CW-1:0] FIFO_RESET_FILL = 13'h0001;
    localparam logic [FIFO_AW-1:0] FIFO_RESET_WR = 12'h001;

    // ==========================================================
    // Command register fields
    localparam int CMD_W = 8;
    localparam logic [CMD_W-1:0] CMD_RESET = 8'h00;
    localparam int C1_GAIN_LSB = 0;
    localparam int C1_CHAN_LSB = 3;
    localparam int C1_SCAN_EN = 6;
    localparam int C1_SIGNED = 7;
    localparam int C2_SOFT_TRIG = 0;
    localparam int C2_HW_TRIG_EN = 1;
    localparam int C4_EXT_BLOCK = 0;
    localparam int C4_PAIRED = 1;
    localparam int C5_SCLK = 0;
    localparam int C5_SOUT = 1;
    localparam int C5_PROM_SEL = 2;
    localparam int C5_PROM_WP_N = 3;
    localparam int C5_TRIM_LOAD = 4;
    localparam int C6_NONREF = 0;
    localparam int C6_UNIPOLAR = 1;
    localparam int C6_ASCEND = 2;
    localparam int FIELD_W = 3;

    // Pin synchroniser layout
    localparam int SYNC_W = 16;

    typedef enum logic {CONV_IDLE, CONV_BUSY} conv_state_e;

endpackage : acq_pkg

// >>> rtl/pin_sync.sv
// Two-flop synchroniser for a group of independent pin levels.
// Assumes each bit is a slow level; no word coherence is promised.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : pin_sync
`default_nettype wire

// >>> rtl/sample_fifo.sv
// Flip-flop FIFO of conversion results.
// Assumes the owner flags pushes made while full; this FIFO drops the word.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo
    import acq_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic push,
    input wire logic [SAMPLE_W-1:0] push_data,
    input wire logic pop,
    output logic [SAMPLE_W-1:0] head,
    output logic [FIFO_CW-1:0] count,
    output logic full
);
    logic [SAMPLE_W-1:0] mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wr_ptr;
    logic [FIFO_AW-1:0] rd_ptr;
    logic do_push;
    logic do_pop;

    assign full = (count == FIFO_FULL);
    assign do_push = push && !full;
    assign do_pop = pop && (count != '0);
    assign head = mem[rd_ptr];

    // ==========================================================
    // Pointers; reset leaves one stale word behind
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr <= FIFO_RESET_WR;
            rd_ptr <= '0;
            count <= FIFO_RESET_FILL;
        end else if (clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + FIFO_CW'(do_push) - FIFO_CW'(do_pop);
        end
    end

    // Storage has no reset on purpose: too many flops to clear
    always_ff @(posedge clk) begin
        if (do_push && !clear) begin
            mem[wr_ptr] <= push_data;
        end
    end
endmodule : sample_fifo
`default_nettype wire

// >>> rtl/acq_control.sv
// Analog input control: command bits, trim serial lines, conversion
// starts, channel scan, result coding and byte-wide FIFO readout.
// Assumes host writes arrive as one-cycle strobes on CLK_SYS and that
// the converter holds ADC_SAMPLE stable at the end of each conversion.
// Function
// (RULE1) Reset clears command bits, status flags and leaves one stale FIFO word.
// (RULE2) After reset the digital port reports basic mode with all lines input.
// (RULE3) Host reads a prom byte: select, opcode, address, one byte in, deselect.
// (RULE4) Host shifts a bit out MSB first, clock low, then raises clock.
// (RULE5) Host shifts a bit in: clock high, clock low, then sample prom bit.
// (RULE6) Host loads trim DAC: address LSB first, constant MSB first, pulse load; the bench shifts the address MSB first.
// (RULE7) FIFO clear never stops an acquisition started by the soft trigger.
// (RULE8) With ext convert block set, ext convert edges start nothing.
// (RULE9) With hw trigger enable clear, ext trigger edges start nothing.
// (RULE10) FIFO clear empties FIFO and flags, keeps command bits unchanged.
// (RULE11) Input mode decodes from bits held in two command registers.
// (RULE12) Polarity bit picks range; coding bit picks binary or two's complement.
// (RULE13) Single channel uses gain and channel fields with scanning off.
// (RULE14) Scan steps down from top to zero, or up from zero, and wraps.
// (RULE15) Second write with scan enable set latches channel into scan counter; with ascending scan set the counter loads zero instead.
// (RULE16) Start convert write accepted only while sample timer output is high.
// (RULE17) Each start launches one conversion, advances scan, pushes after 10 us.
// (RULE18) Data available when FIFO not empty, within 12 us of a start.
// (RULE19) Half full low guarantees 4096 byte reads without underflow.
// (RULE20) Overflow on result lost to full FIFO; overrun on start while busy.
// (RULE21) Sample read as low byte then high byte; reads remove data.
// (RULE22) Flags readable as status outputs of the block.
// (RULE23) A falling sample timer edge starts a conversion; here only with soft trigger set or an ext trigger edge armed.
// (RULE24) Serial command bits drive serial lines directly; prom bit follows pin.
`timescale 1ns/1ps
`default_nettype none
module acq_control
    import acq_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic [CMD_W-1:0] CMD_WDATA,
    input wire logic CMD1_WE,
    input wire logic CMD2_WE,
    input wire logic CMD4_WE,
    input wire logic CMD5_WE,
    input wire logic CMD6_WE,
    input wire logic START_CONVERT_WE,
    input wire logic FIFO_CLEAR_WE,
    input wire logic FIFO_READ,
    input wire logic SAMPLE_TIMER_OUT,
    input wire logic EXT_CONVERT_N,
    input wire logic EXT_TRIGGER,
    input wire logic PROM_DATA,
    input wire logic [ADC_W-1:0] ADC_SAMPLE,
    output logic [CMD_W-1:0] FIFO_BYTE,
    output logic DATA_AVAILABLE,
    output logic FIFO_HALF_FULL_N,
    output logic OVERRUN,
    output logic OVERFLOW,
    output logic PROM_READ_BIT,
    output logic SERIAL_CLOCK,
    output logic SERIAL_OUT_BIT,
    output logic PROM_SELECT,
    output logic PROM_WRITE_PROTECT_N,
    output logic TRIM_DAC_LOAD,
    output logic PAIRED_INPUT_MODE,
    output logic NONREF_SINGLE_ENDED,
    output logic REF_SINGLE_ENDED,
    output logic UNIPOLAR_SELECT,
    output logic [FIELD_W-1:0] GAIN,
    output logic [FIELD_W-1:0] MUX_CHANNEL,
    output logic ADC_START,
    output logic DIO_BASIC_MODE,
    output logic DIO_LINES_INPUT
);
    // ==========================================================
    // Command registers
    logic [CMD_W-1:0] cmd1;
    logic [CMD_W-1:0] cmd2;
    logic [CMD_W-1:0] cmd4;
    logic [CMD_W-1:0] cmd6;

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            cmd1 <= CMD_RESET; // RULE1
            cmd2 <= CMD_RESET; // RULE1
            cmd4 <= CMD_RESET; // RULE1
            cmd6 <= CMD_RESET; // RULE1
        end else begin
            // FIFO clear is not listed here: triggers survive it
            if (CMD1_WE) begin
                cmd1 <= CMD_WDATA;
            end
            if (CMD2_WE) begin
                cmd2 <= CMD_WDATA; // RULE7
            end
            if (CMD4_WE) begin
                cmd4 <= CMD_WDATA;
            end
            if (CMD6_WE) begin
                cmd6 <= CMD_WDATA;
            end
        end
    end

    logic scan_enable;
    logic signed_coding_select;
    logic soft_trigger;
    logic hw_trigger_enable;
    logic ext_convert_block;
    logic scan_ascending;
    logic [FIELD_W-1:0] top_channel;

    assign scan_enable = cmd1[C1_SCAN_EN];
    assign signed_coding_select = cmd1[C1_SIGNED];
    assign soft_trigger = cmd2[C2_SOFT_TRIG];
    assign hw_trigger_enable = cmd2[C2_HW_TRIG_EN];
    assign ext_convert_block = cmd4[C4_EXT_BLOCK];
    assign scan_ascending = cmd6[C6_ASCEND];
    assign top_channel = cmd1[C1_CHAN_LSB +: FIELD_W];

    // ==========================================================
    // Serial calibration lines, held straight in flops
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            SERIAL_CLOCK <= 1'b0; // RULE1
            SERIAL_OUT_BIT <= 1'b0;
            PROM_SELECT <= 1'b0;
            PROM_WRITE_PROTECT_N <= 1'b0;
            TRIM_DAC_LOAD <= 1'b0;
        end else if (CMD5_WE) begin
            SERIAL_CLOCK <= CMD_WDATA[C5_SCLK]; // RULE24
            SERIAL_OUT_BIT <= CMD_WDATA[C5_SOUT]; // RULE24
            PROM_SELECT <= CMD_WDATA[C5_PROM_SEL]; // RULE24
            PROM_WRITE_PROTECT_N <= CMD_WDATA[C5_PROM_WP_N]; // RULE24
            TRIM_DAC_LOAD <= CMD_WDATA[C5_TRIM_LOAD]; // RULE24
        end
    end

    // ==========================================================
    // Pin synchronisers and edge detection
    logic [SYNC_W-1:0] pins_s;
    logic timer_s;
    logic conv_n_s;
    logic trig_s;
    logic [ADC_W-1:0] adc_s;
    logic timer_d;
    logic conv_n_d;
    logic trig_d;

    pin_sync #(.WIDTH(SYNC_W)) u_pin_sync (
        .clk(CLK_SYS),
        .reset(RESET),
        .d({ADC_SAMPLE, PROM_DATA, EXT_TRIGGER, EXT_CONVERT_N,
            SAMPLE_TIMER_OUT}),
        .q(pins_s)
    );

    assign timer_s = pins_s[0];
    assign conv_n_s = pins_s[1];
    assign trig_s = pins_s[2];
    assign adc_s = pins_s[SYNC_W-1 -: ADC_W];

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            timer_d <= 1'b0;
            conv_n_d <= 1'b0;
            trig_d <= 1'b0;
            PROM_READ_BIT <= 1'b0;
        end else begin
            timer_d <= timer_s;
            conv_n_d <= conv_n_s;
            trig_d <= trig_s;
            PROM_READ_BIT <= pins_s[3]; // RULE24
        end
    end

    // ==========================================================
    // Conversion requests
    logic trig_armed;
    logic timer_fall;
    logic ext_conv_edge;
    logic sw_req;
    logic ext_req;
    logic timer_req;
    logic conv_req;

    assign timer_fall = timer_d && !timer_s;
    assign ext_conv_edge = conv_n_d && !conv_n_s;
    assign sw_req = START_CONVERT_WE && timer_s; // RULE16
    assign ext_req = ext_conv_edge && !ext_convert_block; // RULE8
    assign timer_req = timer_fall && (soft_trigger || trig_armed); // RULE23
    assign conv_req = sw_req || ext_req || timer_req;

    // Trigger edge arms timed conversions until hw triggering is disabled
    always_ff @(posedge CLK_SYS) begin
        if (RESET || !hw_trigger_enable) begin
            trig_armed <= 1'b0; // RULE9
        end else if (trig_s && !trig_d) begin
            trig_armed <= 1'b1;
        end
    end

    // ==========================================================
    // Conversion sequencer
    conv_state_e state;
    logic [CONV_CNT_W-1:0] conv_cnt;
    logic accept;
    logic finish;

    assign accept = conv_req && (state == CONV_IDLE);
    assign finish = (state == CONV_BUSY) && (conv_cnt == '0);

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state <= CONV_IDLE;
            conv_cnt <= '0;
        end else begin
            case (state)
                CONV_IDLE: begin
                    if (accept) begin
                        state <= CONV_BUSY; // RULE17
                        conv_cnt <= CONV_LAST;
                    end
                end
                CONV_BUSY: begin
                    if (conv_cnt == '0) begin
                        state <= CONV_IDLE;
                    end else begin
                        conv_cnt <= conv_cnt - CONV_ONE;
                    end
                end
                default: begin
                    state <= CONV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            ADC_START <= 1'b0;
        end else begin
            ADC_START <= accept;
        end
    end

    // ==========================================================
    // Channel scan counter
    logic [FIELD_W-1:0] scan_ch;
    logic [FIELD_W-1:0] next_scan_ch;

    always_comb begin
        if (scan_ascending) begin
            next_scan_ch = (scan_ch == top_channel) ? '0 : scan_ch + 1'b1;
        end else begin
            next_scan_ch = (scan_ch == '0) ? top_channel : scan_ch - 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            scan_ch <= '0;
        end else if (CMD1_WE) begin
            if (CMD_WDATA[C1_SCAN_EN] && !scan_enable) begin
                scan_ch <= scan_ascending ? '0 :
                    CMD_WDATA[C1_CHAN_LSB +: FIELD_W]; // RULE15
            end else if (!CMD_WDATA[C1_SCAN_EN]) begin
                scan_ch <= CMD_WDATA[C1_CHAN_LSB +: FIELD_W]; // RULE13
            end
        end else if (accept && scan_enable) begin
            scan_ch <= next_scan_ch; // RULE14
        end
    end

    // Channel and gain presented to the analog path for each conversion
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            MUX_CHANNEL <= '0;
            GAIN <= '0;
        end else if (accept) begin
            MUX_CHANNEL <= scan_enable ? scan_ch : top_channel; // RULE13
            GAIN <= cmd1[C1_GAIN_LSB +: FIELD_W]; // RULE13
        end
    end

    // ==========================================================
    // Input mode, polarity, digital port state
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            PAIRED_INPUT_MODE <= 1'b0;
            NONREF_SINGLE_ENDED <= 1'b0;
            REF_SINGLE_ENDED <= 1'b1;
            UNIPOLAR_SELECT <= 1'b0;
            DIO_BASIC_MODE <= 1'b1; // RULE2
            DIO_LINES_INPUT <= 1'b1; // RULE2
        end else begin
            PAIRED_INPUT_MODE <= cmd4[C4_PAIRED]; // RULE11
            NONREF_SINGLE_ENDED <= !cmd4[C4_PAIRED] && cmd6[C6_NONREF];
            REF_SINGLE_ENDED <= !cmd4[C4_PAIRED] && !cmd6[C6_NONREF];
            UNIPOLAR_SELECT <= cmd6[C6_UNIPOLAR]; // RULE12
        end
    end

    // ==========================================================
    // Result coding and FIFO
    logic [SAMPLE_W-1:0] coded;
    logic [SAMPLE_W-1:0] head;
    logic [FIFO_CW-1:0] fifo_count;
    logic fifo_full;
    logic byte_hi;
    logic pop;

    // Converter word is offset binary; inverting the top bit gives signed
    assign coded = signed_coding_select ?
        {{(SAMPLE_W - ADC_W + 1){~adc_s[ADC_W-1]}}, adc_s[ADC_W-2:0]} :
        {{(SAMPLE_W - ADC_W){1'b0}}, adc_s}; // RULE12
    assign pop = FIFO_READ && byte_hi; // RULE21

    sample_fifo u_fifo (
        .clk(CLK_SYS),
        .reset(RESET),
        .clear(FIFO_CLEAR_WE), // RULE10
        .push(finish), // RULE17
        .push_data(coded),
        .pop(pop),
        .head(head),
        .count(fifo_count),
        .full(fifo_full)
    );

    // Empty reads return whatever the head holds and do not move pointers
    always_ff @(posedge CLK_SYS) begin
        if (RESET || FIFO_CLEAR_WE) begin
            byte_hi <= 1'b0;
            FIFO_BYTE <= '0;
        end else if (FIFO_READ) begin
            byte_hi <= !byte_hi;
            FIFO_BYTE <= byte_hi ? head[SAMPLE_W-1 -: CMD_W] :
                head[CMD_W-1:0]; // RULE21
        end
    end

    // ==========================================================
    // Status flags; a setting event wins over a clear
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            OVERRUN <= 1'b0; // RULE1
            OVERFLOW <= 1'b0; // RULE1
            DATA_AVAILABLE <= 1'b0;
            FIFO_HALF_FULL_N <= 1'b1;
        end else begin
            if (conv_req && state == CONV_BUSY) begin
                OVERRUN <= 1'b1; // RULE20
            end else if (FIFO_CLEAR_WE) begin
                OVERRUN <= 1'b0; // RULE10
            end
            if (finish && fifo_full) begin
                OVERFLOW <= 1'b1; // RULE20
            end else if (FIFO_CLEAR_WE) begin
                OVERFLOW <= 1'b0; // RULE10
            end
            DATA_AVAILABLE <= (fifo_count != '0); // RULE18 RULE22
            FIFO_HALF_FULL_N <= (fifo_count < FIFO_HALF); // RULE19 RULE22
        end
    end

    // ==========================================================
    // Checks
    logic [CONV_CNT_W-1:0] conv_age;
    logic [FIFO_CW-1:0] dv_wait;

    always_ff @(posedge CLK_SYS) begin
        if (RESET || accept) begin
            conv_age <= RESET ? '0 : CONV_ONE;
        end else if (state == CONV_BUSY) begin
            conv_age <= conv_age + CONV_ONE;
        end
    end

    // Counts cycles a started conversion has waited to show data
    always_ff @(posedge CLK_SYS) begin
        if (RESET || FIFO_CLEAR_WE || DATA_AVAILABLE) begin
            dv_wait <= '0;
        end else if (accept || dv_wait != '0) begin
            dv_wait <= dv_wait + 1'b1;
        end
    end

    sequence s_low_read;
        FIFO_READ && !byte_hi && !FIFO_CLEAR_WE;
    endsequence

    sequence s_low_shown;
        byte_hi && (FIFO_BYTE == $past(head[CMD_W-1:0]));
    endsequence

    a_reset_clears_cmd: assert property (@(posedge CLK_SYS) // RULE1
        RESET |=> cmd1 == '0 && cmd2 == '0 && !OVERRUN && !SERIAL_CLOCK)
        else $error("command state not cleared by reset");
    a_dio_input_mode: assert property (@(posedge CLK_SYS) // RULE2
        $past(RESET) |-> DIO_BASIC_MODE && DIO_LINES_INPUT)
        else $error("digital port not in basic input mode");
    a_clear_keeps_cmd: assert property (@(posedge CLK_SYS) // RULE7
        disable iff (RESET) FIFO_CLEAR_WE && !CMD2_WE |=> $stable(cmd2))
        else $error("fifo clear altered trigger bits");
    a_ext_conv_blocked: assert property (@(posedge CLK_SYS) // RULE8
        disable iff (RESET)
        ext_conv_edge && ext_convert_block && !sw_req && !timer_req
        && state == CONV_IDLE |=> state == CONV_IDLE)
        else $error("blocked ext convert started conversion");
    a_clear_flags: assert property (@(posedge CLK_SYS) // RULE10
        disable iff (RESET) FIFO_CLEAR_WE && !conv_req
        |=> !OVERRUN && fifo_count == '0 ##1 !DATA_AVAILABLE
        && FIFO_HALF_FULL_N)
        else $error("fifo clear left flags or data");
    a_scan_latch: assert property (@(posedge CLK_SYS) // RULE15
        disable iff (RESET) CMD1_WE && CMD_WDATA[C1_SCAN_EN] && !scan_enable
        && !scan_ascending
        |=> scan_ch == $past(CMD_WDATA[C1_CHAN_LSB +: FIELD_W]))
        else $error("scan counter not latched on second write");
    a_timer_gate: assert property (@(posedge CLK_SYS) // RULE16
        disable iff (RESET) START_CONVERT_WE && !timer_s && !ext_req
        && !timer_req && state == CONV_IDLE |=> !ADC_START)
        else $error("start accepted with sample timer low");
    a_push_time: assert property (@(posedge CLK_SYS) // RULE17
        disable iff (RESET) finish |-> conv_age == CONV_FULL)
        else $error("conversion length wrong");
    a_data_available_bound: assert property (@(posedge CLK_SYS) // RULE18
        disable iff (RESET) dv_wait <= FIFO_CW'(DATA_AVAILABLE_CYCLES))
        else $error("data available too late");
    a_overrun_busy: assert property (@(posedge CLK_SYS) // RULE20
        disable iff (RESET) conv_req && state == CONV_BUSY |=> OVERRUN)
        else $error("overrun not flagged");
    a_overflow_full: assert property (@(posedge CLK_SYS) // RULE20
        disable iff (RESET) finish && fifo_full |=> OVERFLOW)
        else $error("overflow not flagged");
    a_low_byte_first: assert property (@(posedge CLK_SYS) // RULE21
        disable iff (RESET) s_low_read |=> s_low_shown)
        else $error("low byte not delivered first");

endmodule : acq_control
`default_nettype wire

// >>> tb/prom_model.sv
// Calibration memory model on the serial command lines.
// Assumes the host toggles clock and data slowly through registers.
`timescale 1ns/1ps
`default_nettype none
module prom_model (
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sel,
    output logic dout
);
    // ==========================================
    // Shift in opcode and address, answer a byte
    localparam logic [7:0] KEY = 8'h5a;
    logic [15:0] sr = 16'h0000;
    int n = 0;
    initial dout = 1'b1;
    always @(posedge sclk or negedge sel) begin
        if (!sel) begin
            n <= 0;
        end else begin
            n <= n + 1;
            if (n < 16) sr <= {sr[14:0], sdi};
        end
    end

    // Answer bits move on the falling clock: the clock is left high
    // after the address, so the host's first raise adds no shift
    always @(negedge sclk or negedge sel) begin
        if (!sel) begin
            // Released line must not keep showing its last bit
            dout <= ~dout;
        end else if (n >= 16 && n < 24) begin
            dout <= sr[23 - n] ^ KEY[23 - n];
        end
    end
endmodule : prom_model
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the analog input control block.
// Assumes the memory model on the serial lines and a fixed converter word.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import acq_pkg::*;
;
    // ==========================================
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] we = 7'h00;
    logic [7:0] wd = 8'h00;
    logic rd_en = 1'b0;
    logic tmr = 1'b1;
    logic ecn = 1'b1;
    logic etr = 1'b0;
    logic [ADC_W-1:0] adc = 12'h123;
    logic pdat, sclk, sdo, psel, pair, rsel, ast, dbm, dli, da, hfn, ovr, ovf;
    logic prb, wp, ld, nrs, uni;
    logic [7:0] fb;
    logic [2:0] gain, mux;
    int n_mismatch = 0;
    int comparisons = 0;

    acq_control i_dut (.CLK_SYS(clk), .RESET(rst), .CMD_WDATA(wd),
        .CMD1_WE(we[1]), .CMD2_WE(we[2]), .CMD4_WE(we[4]), .CMD5_WE(we[5]),
        .CMD6_WE(we[6]), .START_CONVERT_WE(we[0]), .FIFO_CLEAR_WE(we[3]),
        .FIFO_READ(rd_en), .SAMPLE_TIMER_OUT(tmr), .EXT_CONVERT_N(ecn),
        .EXT_TRIGGER(etr), .PROM_DATA(pdat), .ADC_SAMPLE(adc),
        .FIFO_BYTE(fb), .DATA_AVAILABLE(da), .FIFO_HALF_FULL_N(hfn),
        .OVERRUN(ovr), .OVERFLOW(ovf), .PROM_READ_BIT(prb),
        .SERIAL_CLOCK(sclk), .SERIAL_OUT_BIT(sdo), .PROM_SELECT(psel),
        .PROM_WRITE_PROTECT_N(wp), .TRIM_DAC_LOAD(ld),
        .PAIRED_INPUT_MODE(pair),
        .NONREF_SINGLE_ENDED(nrs), .REF_SINGLE_ENDED(rsel),
        .UNIPOLAR_SELECT(uni), .GAIN(gain), .MUX_CHANNEL(mux),
        .ADC_START(ast),
        .DIO_BASIC_MODE(dbm), .DIO_LINES_INPUT(dli));
    prom_model i_prom (.sclk(sclk), .sdi(sdo), .sel(psel), .dout(pdat));

    // ==========================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    // Idle cycle after each strobe so one bit is never set twice at once
    task automatic wr(input int i, input logic [7:0] d);
        we[i] = 1'b1;
        wd = d;
        @(negedge clk);
        we[i] = 1'b0;
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] exp);
        rd_en = 1'b1;
        @(negedge clk);
        chk(fb, exp);
        rd_en = 1'b0;
        @(negedge clk);
    endtask : rd

    task automatic sh(input logic [5:0] hi, input logic [7:0] v,
        input int nb);
        for (int k = nb - 1; k >= 0; k--) begin
            wr(5, {hi, v[k], 1'b0});
            wr(5, {hi, v[k], 1'b1});
            chk({wp, psel, sclk, sdo}, {hi[1:0], 1'b1, v[k]});
        end
    endtask : sh

    // ADC_START stands one cycle, so it is sampled inside the strobe
    task automatic st(output logic a);
        we[0] = 1'b1;
        @(negedge clk);
        a = ast;
        we[0] = 1'b0;
        @(negedge clk);
    endtask : st

    task automatic watch(output logic a);
        a = 1'b0;
        repeat (6) begin
            @(negedge clk);
            a = a | ast;
        end
    endtask : watch

    task automatic wait_da();
        for (int k = 0; k < 2400; k++) begin
            if (da === 1'b1) return;
            @(negedge clk);
        end
        n_mismatch++;
        summarize();
    endtask : wait_da

    // ==========================================
    // Clock and main sequence
    initial begin
        forever #2.5 clk = ~clk;
    end

    initial begin : main
        logic [7:0] b;
        logic s;
        b = 8'h00;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk({ovr, ovf, hfn, rsel, dbm, dli, psel, sclk}, 8'h3c);
        repeat (3) @(negedge clk);
        chk(da, 1'b1);
        wr(4, 8'h02);
        wr(3, 8'h00);
        @(negedge clk);
        chk({da, hfn, pair}, 8'h03);
        sh(6'h03, 8'h03, 8);
        sh(6'h03, 8'h17, 8);
        for (int k = 0; k < 8; k++) begin
            wr(5, 8'h0d);
            wr(5, 8'h0c);
            repeat (2) @(negedge clk);
            b = {b[6:0], prb};
        end
        wr(5, 8'h00);
        chk(b, 8'h4d);
        sh(6'h00, 8'h0a, 4);
        sh(6'h00, 8'h96, 8);
        wr(5, 8'h10);
        chk({ld, psel, wp, sclk}, 8'h08);
        wr(5, 8'h00);
        chk(ld, 1'b0);
        wr(1, 8'h1a);
        st(s);
        chk({s, gain, mux}, 8'h53);
        st(s);
        chk(s, 1'b0);
        @(negedge clk);
        chk(ovr, 1'b1);
        wait_da();
        rd(8'h23);
        rd(8'h01);
        repeat (2) @(negedge clk);
        chk(da, 1'b0);
        tmr = 1'b0;
        repeat (3) @(negedge clk);
        st(s);
        chk(s, 1'b0);
        tmr = 1'b1;
        repeat (3) @(negedge clk);
        wr(4, 8'h00);
        wr(6, 8'h03);
        chk({pair, nrs, rsel, uni}, 8'h05);
        wr(6, 8'h00);
        wr(1, 8'h98);
        wr(1, 8'hd8);
        for (int k = 0; k < 7; k++) begin
            if (k == 5) begin
                wr(6, 8'h04);
                wr(1, 8'h98);
                wr(1, 8'hd8);
            end
            st(s);
            chk(mux, 8'(k < 5 ? (3 - k) & 3 : k - 5));
            repeat (2005) @(negedge clk);
        end
        rd(8'h23);
        rd(8'hf9);
        wr(4, 8'h01);
        ecn = 1'b0;
        watch(s);
        chk(s, 1'b0);
        ecn = 1'b1;
        wr(4, 8'h00);
        ecn = 1'b0;
        watch(s);
        chk(s, 1'b1);
        repeat (2005) @(negedge clk);
        etr = 1'b1;
        tmr = 1'b0;
        watch(s);
        chk(s, 1'b0);
        tmr = 1'b1;
        etr = 1'b0;
        wr(2, 8'h02);
        etr = 1'b1;
        repeat (3) @(negedge clk);
        tmr = 1'b0;
        watch(s);
        chk(s, 1'b1);
        wr(2, 8'h00);
        repeat (2005) @(negedge clk);
        wr(3, 8'h00);
        @(negedge clk);
        chk({ovr, ovf, da, hfn, pair}, 8'h02);
        summarize();
    end
endmodule : testbench
`default_nettype wire
